/* design/rcab_buffer.sv */
// Registered command/address buffer with parity check and rank selects
// Functional notes
// - Strap high: two selects in, two copies out
// - Strap low: four selects in, four out
// - Capture everything on the rising clock edge
// - Word re-driven or written to control words
// - Parity summed, compared with bit next cycle
// - Mismatch pulls open-drain error output low
// - Clock-enable, termination, selects excluded from parity
// - Parity checked only on selected words
// - No word leaving the buffer: data outputs hold still
// - 28-bit fan-out or 26+4 split mode
// - Reset disables receivers, sets every register to its reset value
// - Reset forces outputs to fixed levels
// - Back-side mode keeps all termination on
// - Unused outputs can be disabled
`timescale 1ns/1ps
`default_nettype none

module rcab_buffer (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic quad_select_strap_n,
	input wire logic split_mode_strap,
	input wire logic backside_strap,
	input wire logic pinout_flip,
	input wire logic cmd_valid,
	output var logic cmd_ready,
	input wire logic [rcab_pkg::DATA_W-1:0] cmd_addr_in,
	input wire logic [rcab_pkg::CS_W-1:0] rank_select_in,
	input wire logic [rcab_pkg::CTL_W-1:0] clk_enable_in,
	input wire logic [rcab_pkg::CTL_W-1:0] die_term_in,
	input wire logic parity_in,
	input wire logic out_ready,
	output var logic out_valid,
	output var logic [rcab_pkg::OUT_W-1:0] side_a_data,
	output var logic [rcab_pkg::OUT_W-1:0] side_b_data,
	output var logic [rcab_pkg::CS_W-1:0] rank_select_out,
	output var logic [rcab_pkg::CTL_W-1:0] clk_enable_out,
	output var logic [rcab_pkg::CTL_W-1:0] die_term_out,
	output var logic parity_error_n,
	output var logic parity_error_oe_n,
	output var logic receiver_enable,
	output var logic [1:0] input_termination,
	output var logic quad_mode
);

	// ************************************************************
	// Strap synchronisers
	// ************************************************************
	// Straps are board levels, not clocked by the host
	logic [3:0] strap_meta;                // First stage, read only by second
	logic [3:0] strap_sync;                // Second stage, safe to use
	logic quad_sel;                        // Four-select mode
	logic split_sel;                       // 26+4 fan-out mode
	logic backside_sel;                    // Back-side mount mode
	logic flip_sel;                        // Mirrored pinout

	// Two-flop synchroniser for all four strap pins
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			strap_meta <= 4'hf;
			strap_sync <= 4'hf;
		end
		else
		begin
			strap_meta <= {pinout_flip, backside_strap, split_mode_strap,
				quad_select_strap_n};
			strap_sync <= strap_meta;
		end
	end

	// Strap low selects quad mode; open reads high via board pull-up
	assign quad_sel = !strap_sync[0];
	assign split_sel = strap_sync[1];
	// Back-side mount only exists with two selects
	assign backside_sel = strap_sync[2] && !quad_sel;
	assign flip_sel = strap_sync[3];

	// ************************************************************
	// Receiver enable and input termination
	// ************************************************************
	// Receivers stay off through reset and come up on the first edge after
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			receiver_enable <= 1'b0;
			input_termination <= rcab_pkg::TERM_OFF;
			quad_mode <= 1'b0;
		end
		else
		begin
			receiver_enable <= 1'b1;
			quad_mode <= quad_sel;
			if (backside_sel)
				input_termination <= rcab_pkg::TERM_ALL;
			else if (flip_sel)
				input_termination <= rcab_pkg::TERM_FLIP;
			else
				input_termination <= rcab_pkg::TERM_FRONT;
		end
	end

	// ************************************************************
	// Input decode
	// ************************************************************
	logic [rcab_pkg::CS_W-1:0] cs_eff;     // Selects honoured in this mode
	logic any_sel;                         // Some rank selected
	logic cw_access;                       // Word addresses control words
	logic take;                            // Selected word offered this edge, stalled or not
	logic push;                            // Word goes to the output path
	logic cw_write;                        // Word goes to control words
	logic word_parity;                     // Even sum of address/command bits

	// dual mode ignores selects 2 and 3
	assign cs_eff = quad_sel ? rank_select_in
		: {2'b11, rank_select_in[1:0]};
	assign any_sel = (cs_eff != rcab_pkg::CS_IDLE);
	// All honoured selects low together marks a control word access
	assign cw_access = quad_sel ? (cs_eff == rcab_pkg::QUAD_CS_ALL)
		: (cs_eff == rcab_pkg::DUAL_CS_ALL);
	// Nothing is taken while the receivers are still off
	assign take = receiver_enable && cmd_valid && any_sel;
	assign cw_write = take && cw_access;
	// Back-pressure: the host must hold a word while cmd_ready is low
	assign push = take && !cw_access && cmd_ready;
	// sum covers the command/address bus only
	assign word_parity = ^cmd_addr_in;

	// ************************************************************
	// Control words
	// ************************************************************
	logic [rcab_pkg::CW_VAL_W-1:0] cw [rcab_pkg::CW_COUNT];   // Control word store
	logic [rcab_pkg::CW_IDX_W-1:0] cw_idx;                   // Addressed word
	logic [rcab_pkg::CW_VAL_W-1:0] cw_val;                   // Value to store
	logic [rcab_pkg::CW_VAL_W-1:0] out_dis;                  // Output disable word

	assign cw_idx = cmd_addr_in[rcab_pkg::CW_IDX_LSB +: rcab_pkg::CW_IDX_W];
	assign cw_val = cmd_addr_in[rcab_pkg::CW_VAL_LSB +: rcab_pkg::CW_VAL_W];
	assign out_dis = cw[rcab_pkg::CW_OUT_DIS];

	// One register per control word, written by index
	genvar gi;
	generate
		for (gi = 0; gi < rcab_pkg::CW_COUNT; gi++)
		begin : g_cw
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
					cw[gi] <= rcab_pkg::CW_RESET;
				else if (cw_write && (cw_idx == rcab_pkg::CW_IDX_W'(gi)))
					cw[gi] <= cw_val;
			end
		end
	endgenerate

	// ************************************************************
	// Parity check
	// ************************************************************
	logic par_pending;                     // A checked word awaits its bit
	logic par_sum;                         // Sum of that word

	// Remember the sum of each selected word for the next cycle
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			par_pending <= 1'b0;
			par_sum <= 1'b0;
		end
		else
		begin
			// only selected words checked
			// A stalled word is not pushed yet, so it is not checked yet
			par_pending <= push || cw_write;
			par_sum <= word_parity;
		end
	end

	// Compare with the bit that arrives one cycle later
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			parity_error_n <= 1'b1;
			parity_error_oe_n <= 1'b1;
		end
		else if (par_pending)
		begin
			parity_error_n <= (par_sum == parity_in);
			parity_error_oe_n <= (par_sum == parity_in);
		end
	end

	// ************************************************************
	// Word buffer between capture and re-drive
	// ************************************************************
	rcab_pkg::rcab_word_s in_word;         // Captured word and selects
	rcab_pkg::rcab_word_s head;            // Oldest buffered word
	logic head_valid;
	logic head_take;

	assign in_word.cs = cs_eff;
	assign in_word.data = cmd_addr_in;

	// Eight words absorb downstream stalls; full reaches the host
	rcab_fifo #(
		.WIDTH(rcab_pkg::WORD_W),
		.DEPTH(rcab_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_b(rst_b),
		.in_valid(push),
		.in_ready(cmd_ready),
		.in_data(in_word),
		.out_valid(head_valid),
		.out_ready(out_ready),
		.out_data(head)
	);

	assign head_take = head_valid && out_ready;

	// ************************************************************
	// Re-drive stage
	// ************************************************************
	logic [rcab_pkg::OUT_W-1:0] next_a;    // Side A image of the head word
	logic [rcab_pkg::OUT_W-1:0] next_b;    // Side B image of the head word

	// Fan-out map for the head word
	always_comb
	begin
		next_a = head.data[rcab_pkg::OUT_W-1:0];
		next_b = head.data[rcab_pkg::OUT_W-1:0];
		if (split_sel)
		begin
			next_a[rcab_pkg::OUT_W-1:rcab_pkg::FAN_W] =
				head.data[rcab_pkg::FAN_W +: rcab_pkg::SPLIT_HALF];
			next_b[rcab_pkg::OUT_W-1:rcab_pkg::FAN_W] =
				head.data[rcab_pkg::FAN_W + rcab_pkg::SPLIT_HALF +: rcab_pkg::SPLIT_HALF];
		end
	end

	// Data outputs load only when a selected word leaves the buffer
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			side_a_data <= rcab_pkg::DATA_RESET;
			side_b_data <= rcab_pkg::DATA_RESET;
		end
		else if (head_take)
		begin
			side_a_data <= next_a;
			if (!out_dis[rcab_pkg::OD_SIDE_B])
				side_b_data <= next_b;
		end
	end

	// Selects and valid mark the one cycle a word is re-driven
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rank_select_out <= rcab_pkg::CS_IDLE;
			out_valid <= 1'b0;
		end
		else
		begin
			out_valid <= head_take;
			if (!head_take)
				rank_select_out <= rcab_pkg::CS_IDLE;
			else if (quad_sel)
				rank_select_out <= head.cs;
			else
				rank_select_out <= {head.cs[1:0], head.cs[1:0]};
		end
	end

	// ************************************************************
	// Clock-enable and termination pass-through
	// ************************************************************
	// These bypass the buffer: they must track the host cycle by cycle
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clk_enable_out <= rcab_pkg::CTL_RESET;
			die_term_out <= rcab_pkg::CTL_RESET;
		end
		else if (receiver_enable)
		begin
			clk_enable_out[0] <= clk_enable_in[0];
			die_term_out[0] <= die_term_in[0];
			if (out_dis[rcab_pkg::OD_RANK1_CTL])
			begin
				clk_enable_out[1] <= 1'b0;
				die_term_out[1] <= 1'b0;
			end
			else
			begin
				clk_enable_out[1] <= clk_enable_in[1];
				die_term_out[1] <= die_term_in[1];
			end
		end
	end

endmodule

`default_nettype wire

/* design/rcab_pkg.sv */
// Shared constants and carrier types for the registered command/address buffer
package rcab_pkg;

	// ************************************************************
	// Widths of the command/address path
	// ************************************************************
	localparam int DATA_W = 30;            // Pins on the command/address input bus
	localparam int FAN_W = 26;             // Low part that always fans out one-to-two
	localparam int OUT_W = 28;             // Width of each output side
	localparam int SPLIT_W = 4;            // One-to-one part in split mode
	localparam int SPLIT_HALF = 2;         // One-to-one bits landing on each side
	localparam int CS_W = 4;               // Rank selects, active low
	localparam int CTL_W = 2;              // Clock-enable and termination pins
	localparam int FIFO_DEPTH = 8;         // Words held between capture and re-drive

	// ************************************************************
	// Control word access
	// ************************************************************
	localparam int CW_COUNT = 16;          // Internal control words
	localparam int CW_IDX_W = 4;           // Index width
	localparam int CW_VAL_W = 4;           // Value width
	localparam int CW_IDX_LSB = 0;         // Index field position in the data word
	localparam int CW_VAL_LSB = 4;         // Value field position in the data word
	localparam logic [CW_IDX_W-1:0] CW_OUT_DIS = 4'h0;   // Output disable word
	localparam int OD_SIDE_B = 0;          // Disable side B data outputs
	localparam int OD_RANK1_CTL = 1;       // Disable clock-enable/termination 1
	localparam logic [CW_VAL_W-1:0] CW_RESET = 4'h0;     // Control word reset value

	// ************************************************************
	// Reset levels, select patterns and termination codes
	// ************************************************************
	localparam logic [CS_W-1:0] CS_IDLE = 4'hf;          // No rank selected
	localparam logic [CS_W-1:0] DUAL_CS_ALL = 4'hc;      // Both dual selects low
	localparam logic [CS_W-1:0] QUAD_CS_ALL = 4'h0;      // All quad selects low
	localparam logic [OUT_W-1:0] DATA_RESET = 28'h0000000;
	localparam logic [CTL_W-1:0] CTL_RESET = 2'h0;
	localparam logic [1:0] TERM_OFF = 2'h0;
	localparam logic [1:0] TERM_ALL = 2'h3;
	localparam logic [1:0] TERM_FRONT = 2'h1;            // Normal pinout group
	localparam logic [1:0] TERM_FLIP = 2'h2;             // Mirrored pinout group

	// ************************************************************
	// Carrier types
	// ************************************************************
	// One captured command/address word with its selects
	typedef struct packed {
		logic [CS_W-1:0] cs;
		logic [DATA_W-1:0] data;
	} rcab_word_s;

	localparam int WORD_W = $bits(rcab_word_s);

endpackage

/* design/rcab_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rcab_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic in_valid,
	output var logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output var logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];         // Storage, one flop row per entry
	logic [PTR_W-1:0] wr_ptr;              // Next entry to fill
	logic [PTR_W-1:0] rd_ptr;              // Oldest entry
	logic [PTR_W:0] count;                 // Entries held
	logic [PTR_W:0] next_count;
	logic push;
	logic pop;

	// Handshakes; flags are registered so they are honest
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// Occupancy after this edge
	always_comb
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + (PTR_W+1)'(1);
		else if (pop && !push)
			next_count = count - (PTR_W+1)'(1);
	end

	// Pointers, count and flags
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PTR_W'(1);
			if (pop)
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PTR_W'(1);
			count <= next_count;
			in_ready <= (next_count != FULL_COUNT);
			out_valid <= (next_count != '0);
		end
	end

	// Entry storage, written only on a push
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
		end
		else if (push)
		begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule

`default_nettype wire

/* tb/rcab_host_model.sv */
// Host controller model driving the command/address bus
`timescale 1ns/1ps
`default_nettype none
module rcab_host_model (
	input wire logic clock,
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [rcab_pkg::DATA_W-1:0] cmd_addr_in,
	output logic [rcab_pkg::CS_W-1:0] rank_select_in,
	output logic parity_in
);
	// ************************************************************
	// Bus drive
	// ************************************************************
	// Idle bus at time zero
	initial
	begin
		cmd_valid = 1'b0;
		cmd_addr_in = '0;
		rank_select_in = rcab_pkg::CS_IDLE;
		parity_in = 1'b0;
	end
	// Offer a word and hold it until the buffer can take it
	task automatic send(input logic [29:0] d, input logic [3:0] cs, input logic bad);
		cmd_valid <= 1'b1;
		cmd_addr_in <= d;
		rank_select_in <= cs;
		// Hold the word through every edge at which the buffer is full
		@(posedge clock);
		while (cmd_ready !== 1'b1)
			@(posedge clock);
		cmd_valid <= 1'b0;
		rank_select_in <= rcab_pkg::CS_IDLE;
		parity_in <= (^d) ^ bad;
		// Deselected bus must not look stale
		cmd_addr_in <= ~d;
		@(posedge clock);
		// Released parity line flips so a late look fails
		parity_in <= ~((^d) ^ bad);
	endtask
endmodule
`default_nettype wire

/* tb/rcab_buffer_checker.sv */
// Port-level assertions for the command/address buffer
`timescale 1ns/1ps
`default_nettype none
module rcab_buffer_checker (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic quad_select_strap_n,
	input wire logic backside_strap,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [rcab_pkg::DATA_W-1:0] cmd_addr_in,
	input wire logic [rcab_pkg::CS_W-1:0] rank_select_in,
	input wire logic [rcab_pkg::CTL_W-1:0] clk_enable_in,
	input wire logic [rcab_pkg::CTL_W-1:0] die_term_in,
	input wire logic parity_in,
	input wire logic out_valid,
	input wire logic [rcab_pkg::OUT_W-1:0] side_a_data,
	input wire logic [rcab_pkg::OUT_W-1:0] side_b_data,
	input wire logic [rcab_pkg::CS_W-1:0] rank_select_out,
	input wire logic [rcab_pkg::CTL_W-1:0] clk_enable_out,
	input wire logic [rcab_pkg::CTL_W-1:0] die_term_out,
	input wire logic parity_error_n,
	input wire logic parity_error_oe_n,
	input wire logic receiver_enable,
	input wire logic [1:0] input_termination,
	input wire logic quad_mode
);
	// Some honoured select low for the current mode
	logic sel;
	logic cw;
	logic take;
	assign sel = quad_mode ? (rank_select_in != 4'hf) : (rank_select_in[1:0] != 2'h3);
	// Control words go in even while the buffer is full
	assign cw = quad_mode ? (rank_select_in == 4'h0) : (rank_select_in[1:0] == 2'h0);
	assign take = receiver_enable && cmd_valid && sel && (cmd_ready || cw);
	// ************************************************************
	// Parity steps, then reset, output and strap checks
	// ************************************************************
	sequence s_take;
		take;
	endsequence
	sequence s_parity_done;
		##2 (parity_error_n == ($past(parity_in) == ^$past(cmd_addr_in, 2)));
	endsequence
	a_parity_result: assert property (@(posedge clock) disable iff (!rst_b) s_take |-> s_parity_done)
		else $error("parity result wrong");
	a_error_pin_pair: assert property (@(posedge clock) parity_error_oe_n == parity_error_n)
		else $error("error enable differs");
	a_error_holds: assert property (@(posedge clock) disable iff (!rst_b)
		!take |-> ##2 $stable(parity_error_n))
		else $error("error moved without word");
	a_reset_outputs: assert property (@(posedge clock) !rst_b |-> side_a_data == 28'h0
		&& side_b_data == 28'h0 && rank_select_out == 4'hf && parity_error_n)
		else $error("outputs not at reset level");
	a_reset_receivers: assert property (@(posedge clock) !rst_b |-> !receiver_enable
		&& !cmd_ready && !out_valid && input_termination == 2'h0)
		else $error("receivers not off in reset");
	a_data_hold: assert property (@(posedge clock) disable iff (!rst_b)
		!out_valid |-> $stable(side_a_data) && $stable(side_b_data))
		else $error("data moved without word");
	a_select_idle: assert property (@(posedge clock) disable iff (!rst_b)
		!out_valid |-> rank_select_out == 4'hf)
		else $error("select out of pulse");
	a_dual_copies: assert property (@(posedge clock) disable iff (!rst_b)
		out_valid && !quad_mode |-> rank_select_out[3:2] == rank_select_out[1:0])
		else $error("dual copies differ");
	a_ctl_passthru: assert property (@(posedge clock) disable iff (!rst_b)
		receiver_enable && $past(receiver_enable) |=> clk_enable_out[0] == $past(clk_enable_in[0])
		&& die_term_out[0] == $past(die_term_in[0]))
		else $error("control pass wrong");
	a_backside_term: assert property (@(posedge clock) disable iff (!rst_b)
		(backside_strap && quad_select_strap_n)[*5] |-> input_termination == 2'h3)
		else $error("backside termination off");
	a_quad_strap: assert property (@(posedge clock) disable iff (!rst_b)
		(!quad_select_strap_n)[*5] |-> quad_mode)
		else $error("quad mode not taken");
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the command/address buffer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
	logic clock = 1'b0;
	logic rst_b = 1'b1;
	logic quad_select_strap_n = 1'b1;
	logic split_mode_strap = 1'b0;
	logic backside_strap = 1'b0;
	logic pinout_flip = 1'b0;
	logic out_ready = 1'b1;
	logic [1:0] clk_enable_in = 2'h0;
	logic [1:0] die_term_in = 2'h0;
	logic cmd_valid, cmd_ready, parity_in, out_valid, parity_error_n, parity_error_oe_n;
	logic receiver_enable, quad_mode;
	logic [29:0] cmd_addr_in;
	logic [3:0] rank_select_in, rank_select_out;
	logic [27:0] side_a_data, side_b_data;
	logic [1:0] clk_enable_out, die_term_out, input_termination;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	always #5 clock = ~clock;
	rcab_host_model i_rcab_host_model (.clock, .cmd_ready, .cmd_valid, .cmd_addr_in,
		.rank_select_in, .parity_in);
	rcab_buffer i_rcab_buffer (.clock, .rst_b, .quad_select_strap_n, .split_mode_strap,
		.backside_strap, .pinout_flip, .cmd_valid, .cmd_ready, .cmd_addr_in, .rank_select_in,
		.clk_enable_in, .die_term_in, .parity_in, .out_ready, .out_valid, .side_a_data,
		.side_b_data, .rank_select_out, .clk_enable_out, .die_term_out, .parity_error_n,
		.parity_error_oe_n, .receiver_enable, .input_termination, .quad_mode);
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Side B lanes: split puts bits 29:28 on the top pair
	function automatic logic [27:0] fan_b(input logic [29:0] d);
		return split_mode_strap ? {d[29:28], d[25:0]} : d[27:0];
	endfunction
	// Wait a bounded time for the re-drive pulse and check it
	task automatic wait_out(input logic [29:0] d, input logic [27:0] b, input logic [3:0] cs);
		int n;
		n = 0;
		// The pulse may already stand when the caller arrives
		while (out_valid !== 1'b1 && n < 12)
		begin
			@(negedge clock);
			n++;
		end
		`CHK("out_valid", 1'b1, out_valid)
		`CHK("side_a", d[27:0], side_a_data)
		`CHK("side_b", b, side_b_data)
		`CHK("select", quad_select_strap_n ? {cs[1:0], cs[1:0]} : cs, rank_select_out)
		// Step past this pulse so the next call sees the next word
		@(negedge clock);
	endtask
	// One word through: parity answer, then the re-drive
	task automatic xfer(input logic [29:0] d, input logic [3:0] cs, input logic bad,
		input logic [27:0] b);
		i_rcab_host_model.send(d, cs, bad);
		@(negedge clock);
		`CHK("parity_error_n", ~bad, parity_error_n)
		wait_out(d, b, cs);
		@(posedge clock);
	endtask
	// Hang guard, well above the run length
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			report_and_stop();
		end
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		// Reset from time zero so outputs are settled at the first edge
		rst_b <= 1'b0;
		repeat (8) @(posedge clock);
		`CHK("rst side_a", rcab_pkg::DATA_RESET, side_a_data)
		`CHK("rst rx", 1'b0, receiver_enable)
		rst_b <= 1'b1;
		// Straps need two edges, termination one more
		repeat (4) @(posedge clock);
		`CHK("rx on", 1'b1, receiver_enable)
		`CHK("term", rcab_pkg::TERM_FRONT, input_termination)
		xfer(30'h2aaa5555, 4'he, 1'b0, fan_b(30'h2aaa5555));
		xfer(30'h12345678, 4'hd, 1'b1, fan_b(30'h12345678));
		repeat (4) @(posedge clock);
		`CHK("err held", 1'b0, parity_error_n)
		`CHK("data held", 28'h2345678, side_a_data)
		clk_enable_in <= 2'h3;
		die_term_in <= 2'h2;
		xfer(30'h1, 4'he, 1'b0, 28'h1);
		`CHK("cke out", 2'h3, clk_enable_out)
		`CHK("odt out", 2'h2, die_term_out)
		// Both selects low: freeze side B, nothing re-driven
		i_rcab_host_model.send(30'h10, 4'hc, 1'b0);
		repeat (4) @(negedge clock) `CHK("cw pulse", 1'b0, out_valid)
		@(posedge clock);
		xfer(30'h0abcdef0, 4'he, 1'b0, 28'h1);
		i_rcab_host_model.send(30'h20, 4'hc, 1'b0);
		repeat (2) @(posedge clock);
		`CHK("cke1 off", 2'h1, clk_enable_out)
		i_rcab_host_model.send(30'h0, 4'hc, 1'b0);
		split_mode_strap <= 1'b1;
		repeat (4) @(posedge clock);
		xfer(30'h2c000003, 4'hd, 1'b0, fan_b(30'h2c000003));
		split_mode_strap <= 1'b0;
		backside_strap <= 1'b1;
		pinout_flip <= 1'b1;
		repeat (5) @(posedge clock);
		`CHK("term all", rcab_pkg::TERM_ALL, input_termination)
		backside_strap <= 1'b0;
		repeat (5) @(posedge clock);
		`CHK("term flip", rcab_pkg::TERM_FLIP, input_termination)
		pinout_flip <= 1'b0;
		quad_select_strap_n <= 1'b0;
		repeat (5) @(posedge clock);
		`CHK("quad", 1'b1, quad_mode)
		xfer(30'h0f0f0f0f, 4'h7, 1'b0, fan_b(30'h0f0f0f0f));
		// Fill the buffer while the far side stalls, then drain it
		out_ready <= 1'b0;
		for (int i = 0; i < 8; i++)
			i_rcab_host_model.send(30'h100 + 30'(i), 4'hb, 1'b0);
		@(negedge clock);
		`CHK("full", 1'b0, cmd_ready)
		@(posedge clock);
		out_ready <= 1'b1;
		for (int i = 0; i < 8; i++)
			wait_out(30'h100 + 30'(i), 28'h100 + 28'(i), 4'hb);
		@(posedge clock);
		rst_b <= 1'b0;
		@(negedge clock);
		`CHK("rerst select", rcab_pkg::CS_IDLE, rank_select_out)
		`CHK("rerst ready", 1'b0, cmd_ready)
		report_and_stop();
	end
endmodule
bind rcab_buffer rcab_buffer_checker i_rcab_buffer_checker (.clock, .rst_b,
	.quad_select_strap_n, .backside_strap, .cmd_valid, .cmd_ready, .cmd_addr_in,
	.rank_select_in, .clk_enable_in, .die_term_in, .parity_in, .out_valid, .side_a_data,
	.side_b_data, .rank_select_out, .clk_enable_out, .die_term_out, .parity_error_n,
	.parity_error_oe_n, .receiver_enable, .input_termination, .quad_mode);
`default_nettype wire
